// File: verilog/loop_transceiver_startup_sequencer.sv
// start-up and reset sequencer of the customer side termination
// assumes receiver status, frame ticks and user bits come from sys_clk logic
`timescale 1ns/1ps
`include "loop_seq_defines.svh"

module loop_transceiver_startup_sequencer
    import loop_seq_pkg::*;
#(
    parameter count_t RECV_RESET_CYC = 32'(`RECV_RESET_MS * `CLK_KHZ),
    parameter count_t LOSS_LIMIT_CYC = 32'(`LOSS_LIMIT_MS * `CLK_KHZ),
    parameter count_t STARTUP_LIMIT_CYC = 32'(`STARTUP_LIMIT_S * `CLK_HZ)
)
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic frame_tick,
    input wire logic signal_detect,
    input wire logic exchange_wake_tone_detect,
    input wire logic service_request,
    input wire logic line_changed,
    input wire logic frame_sync_acquired,
    input wire logic exchange_pattern_two_detect,
    input wire logic multiframe_acquired,
    input wire logic echo_converged,
    input wire logic equalizer_converged,
    input wire logic far_activation_bit,
    input wire logic far_deact_bit,
    input wire logic loopback_req,
    input wire logic line_user_bit,
    input wire logic te_user_bit_in,
    output logic tx_on,
    output logic tone_on,
    output logic tone_positive,
    output logic tone_strobe,
    output logic scramble_en,
    output logic inverted_sync_en,
    output logic overhead_normal,
    output logic tx_user_bit,
    output logic te_user_bit,
    output logic transparent,
    output logic full_operational,
    output logic warm_start,
    output t_point_t t_point
);

    seq_state_e state_reg;
    seq_state_e state_next;
    count_t state_cnt_reg;
    count_t state_cnt_next;
    count_t startup_cnt_reg;
    count_t startup_cnt_next;
    count_t los_cnt_reg;
    count_t los_cnt_next;
    count_t lsync_cnt_reg;
    count_t lsync_cnt_next;
    logic [2:0] frame_cnt_reg;
    logic [2:0] frame_cnt_next;
    logic powerup_reg;
    logic powerup_next;
    logic svc_prev_reg;
    logic svc_prev_next;
    logic warm_ok_reg;
    logic warm_ok_next;
    logic turnoff_prep_reg;
    logic turnoff_prep_next;
    logic warm_start_reg;
    logic warm_start_next;
    logic tx_user_bit_reg;
    logic tx_user_bit_next;
    logic te_user_bit_reg;
    logic te_user_bit_next;
    logic transparent_comb;
    logic operational_comb;
    logic svc_rise;

    // saturating increment of a timer word
    function automatic count_t count_up(input count_t value);
        count_up = (value == 32'hFFFF_FFFF) ? value : value + 32'h0000_0001;
    endfunction

    // true in either reset sub-state
    function automatic logic in_reset(input seq_state_e s);
        in_reset = (s == FULL_RESET) || (s == RECV_RESET);
    endfunction

    // readiness for full operation and transparency
    assign operational_comb = frame_sync_acquired && multiframe_acquired
        && echo_converged && equalizer_converged;
    assign transparent_comb = (state_reg == PATTERN_FINAL) && operational_comb
        && far_activation_bit && far_deact_bit;
    assign svc_rise = service_request && !svc_prev_reg;

    // state machine and timers
    always_comb begin
        state_next = state_reg;
        state_cnt_next = count_up(state_cnt_reg);
        startup_cnt_next = startup_cnt_reg;
        los_cnt_next = signal_detect ? 32'h0000_0000 : count_up(los_cnt_reg);
        lsync_cnt_next = (frame_sync_acquired && multiframe_acquired) ? 32'h0000_0000
            : count_up(lsync_cnt_reg);
        frame_cnt_next = frame_cnt_reg;
        powerup_next = powerup_reg;
        svc_prev_next = service_request;
        warm_ok_next = warm_ok_reg && !line_changed;
        turnoff_prep_next = turnoff_prep_reg;
        warm_start_next = warm_start_reg;
        if (!in_reset(state_reg) && state_reg != PATTERN_FINAL) begin
            startup_cnt_next = count_up(startup_cnt_reg);
        end
        unique case (state_reg)
            FULL_RESET: begin
                // start only on power-up, new service request or exchange tone
                if (exchange_wake_tone_detect || powerup_reg || svc_rise) begin
                    state_next = WAKE_TONE;
                end
            end
            RECV_RESET: begin
                if (exchange_wake_tone_detect) begin
                    state_next = WAKE_TONE;
                end else if (state_cnt_reg >= RECV_RESET_CYC - 32'h0000_0001) begin
                    state_next = FULL_RESET;
                end
            end
            WAKE_TONE: begin
                if (frame_tick) begin
                    frame_cnt_next = frame_cnt_reg + 3'h1;
                end
                if (frame_tick && frame_cnt_reg == `CUST_TONE_FRAMES - 3'h1) begin
                    state_next = PATTERN_ONE;
                end
            end
            PATTERN_ONE: begin
                if (echo_converged) begin
                    state_next = SILENT_WAIT;
                end
            end
            SILENT_WAIT: begin
                if (signal_detect) begin
                    state_next = RX_TRAIN;
                end else if (state_cnt_reg >= LOSS_LIMIT_CYC) begin
                    state_next = FULL_RESET;
                end
            end
            RX_TRAIN: begin
                if (frame_sync_acquired && exchange_pattern_two_detect) begin
                    state_next = PATTERN_TWO;
                end
            end
            PATTERN_TWO: begin
                if (operational_comb) begin
                    state_next = PATTERN_FINAL;
                end
            end
            PATTERN_FINAL: begin
                // announced turn-off prepares a warm restart
                if (!far_deact_bit) begin
                    turnoff_prep_next = 1'b1;
                end
                if (turnoff_prep_reg && !signal_detect) begin
                    state_next = RECV_RESET;
                end else if (los_cnt_reg >= LOSS_LIMIT_CYC) begin
                    state_next = RECV_RESET;
                end else if (lsync_cnt_reg >= LOSS_LIMIT_CYC) begin
                    state_next = CEASE_WAIT;
                end
            end
            CEASE_WAIT: begin
                if (!signal_detect) begin
                    state_next = RECV_RESET;
                end
            end
        endcase
        // start-up taking too long stops transmission
        if (!in_reset(state_reg) && state_reg != PATTERN_FINAL && state_reg != CEASE_WAIT
            && startup_cnt_reg >= STARTUP_LIMIT_CYC) begin
            state_next = CEASE_WAIT;
        end
        if (state_next == CEASE_WAIT) begin
            warm_ok_next = 1'b0;
        end
        if (state_reg == PATTERN_FINAL && state_next == RECV_RESET) begin
            warm_ok_next = turnoff_prep_reg && !line_changed;
        end
        if (state_next != state_reg) begin
            state_cnt_next = 32'h0000_0000;
        end
        if (state_next == WAKE_TONE && state_reg != WAKE_TONE) begin
            frame_cnt_next = 3'h0;
            startup_cnt_next = 32'h0000_0000;
            powerup_next = 1'b0;
            warm_start_next = warm_ok_reg && !line_changed;
            warm_ok_next = 1'b0;
        end
        if (in_reset(state_next)) begin
            turnoff_prep_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= FULL_RESET;
            state_cnt_reg <= 32'h0000_0000;
            startup_cnt_reg <= 32'h0000_0000;
            los_cnt_reg <= 32'h0000_0000;
            lsync_cnt_reg <= 32'h0000_0000;
            frame_cnt_reg <= 3'h0;
            powerup_reg <= 1'b1;
            svc_prev_reg <= 1'b0;
            warm_ok_reg <= 1'b0;
            turnoff_prep_reg <= 1'b0;
            warm_start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            state_cnt_reg <= state_cnt_next;
            startup_cnt_reg <= startup_cnt_next;
            los_cnt_reg <= los_cnt_next;
            lsync_cnt_reg <= lsync_cnt_next;
            frame_cnt_reg <= frame_cnt_next;
            powerup_reg <= powerup_next;
            svc_prev_reg <= svc_prev_next;
            warm_ok_reg <= warm_ok_next;
            turnoff_prep_reg <= turnoff_prep_next;
            warm_start_reg <= warm_start_next;
        end
    end

    // user bit paths, fixed fill unless transparent; looping back replaces only the line fill bit
    always_comb begin
        tx_user_bit_next = `CUST_FILL_BIT;
        te_user_bit_next = `TE_IDLE_BIT;
        if (transparent_comb) begin
            tx_user_bit_next = te_user_bit_in;
            te_user_bit_next = line_user_bit;
        end else if (state_reg == PATTERN_FINAL && loopback_req) begin
            tx_user_bit_next = line_user_bit;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_user_bit_reg <= `CUST_FILL_BIT;
            te_user_bit_reg <= `TE_IDLE_BIT;
        end else begin
            tx_user_bit_reg <= tx_user_bit_next;
            te_user_bit_reg <= te_user_bit_next;
        end
    end

    // transmit controls decoded from the state register
    assign tx_on = !in_reset(state_reg) && state_reg != SILENT_WAIT
        && state_reg != RX_TRAIN && state_reg != CEASE_WAIT;
    assign tone_on = (state_reg == WAKE_TONE);
    assign scramble_en = tx_on && !tone_on;
    assign inverted_sync_en = (state_reg == PATTERN_FINAL);
    assign overhead_normal = (state_reg == PATTERN_FINAL);
    assign tx_user_bit = tx_user_bit_reg;
    assign te_user_bit = te_user_bit_reg;
    assign full_operational = (state_reg == PATTERN_FINAL) && operational_comb;
    assign warm_start = warm_start_reg;

    // transition point shown from the state
    always_comb begin
        unique case (state_reg)
            WAKE_TONE, PATTERN_ONE: t_point = 3'h1;
            SILENT_WAIT: t_point = 3'h2;
            RX_TRAIN: t_point = 3'h3;
            PATTERN_TWO: t_point = 3'h5;
            PATTERN_FINAL: t_point = 3'h6;
            default: t_point = 3'h0;
        endcase
    end

    // transparency flag follows the same cycle as the user bits
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            transparent <= 1'b0;
        end else begin
            transparent <= transparent_comb;
        end
    end

    wake_tone_gen tone_gen_i (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .tone_on(tone_on),
        .tone_positive(tone_positive),
        .tone_strobe(tone_strobe)
    );

    // steps of start-up and reset, each named for the event it matches and used by one check
    sequence tone_ends_s;
        $fell(tone_on);
    endsequence
    sequence reset_leaves_recv_s;
        $past(state_reg) == RECV_RESET && state_reg == FULL_RESET;
    endsequence

    reset_silent_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        in_reset(state_reg) |-> !tx_on && !tone_on)
        else $error("transmitting in reset");
    recv_dwell_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        reset_leaves_recv_s |-> $past(state_cnt_reg) >= RECV_RESET_CYC - 32'h0000_0001)
        else $error("receive reset left early");
    wake_answer_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_reg == RECV_RESET && exchange_wake_tone_detect) |=> tone_on)
        else $error("exchange tone not answered");
    tone_length_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        tone_ends_s |-> state_reg == CEASE_WAIT
            || $past(frame_cnt_reg) == `CUST_TONE_FRAMES - 3'h1)
        else $error("tone length wrong");
    fill_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!transparent_comb && !(state_reg == PATTERN_FINAL && loopback_req))
        |=> tx_user_bit == `CUST_FILL_BIT && te_user_bit == `TE_IDLE_BIT)
        else $error("user bits leaked while not transparent");
    pass_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        transparent_comb |=> tx_user_bit == $past(te_user_bit_in)
            && te_user_bit == $past(line_user_bit) && transparent)
        else $error("transparent path broken");
    tone_unscrambled_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        tone_on |-> !scramble_en && !inverted_sync_en && tx_on)
        else $error("tone scrambled or framed");
    t2_silent_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_reg == PATTERN_ONE && echo_converged && startup_cnt_reg < STARTUP_LIMIT_CYC)
        |=> !tx_on && t_point == 3'h2)
        else $error("still transmitting at T2");
    final_entry_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(inverted_sync_en) |-> $past(state_reg) == PATTERN_TWO && $past(operational_comb))
        else $error("final pattern without multiframe");
    startup_limit_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (startup_cnt_reg >= STARTUP_LIMIT_CYC && !in_reset(state_reg)
            && state_reg != PATTERN_FINAL)
        |=> !tx_on && (state_reg == CEASE_WAIT || in_reset(state_reg)))
        else $error("start-up limit ignored");
    full_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_reg == FULL_RESET && !powerup_reg && !svc_rise && !exchange_wake_tone_detect)
        |=> state_reg == FULL_RESET)
        else $error("spontaneous start from full reset");

endmodule

// File: include/loop_seq_defines.svh
// constants of the loop transceiver start-up sequencer
// assumes a single 200 MHz system clock; times are kept in their own units
`ifndef LOOP_SEQ_DEFINES_SVH
`define LOOP_SEQ_DEFINES_SVH

// system clock rate in kHz, so that a time in ms times this is a cycle count
`define CLK_KHZ 64'h0000_0000_0003_0D40
// clock rate in Hz
`define CLK_HZ 64'h0000_0000_0BEB_C200

// receive reset dwell, ms (least time)
`define RECV_RESET_MS 64'h0000_0000_0000_0028
// loss of signal or sync limit, ms
`define LOSS_LIMIT_MS 64'h0000_0000_0000_01E0
// start-up completion limit, s
`define STARTUP_LIMIT_S 64'h0000_0000_0000_000F
// wake answer limit, ms (longest time)
`define WAKE_ANSWER_MS 64'h0000_0000_0000_0004

// wake tone frequency in Hz and symbols per tone period
`define TONE_HZ 64'h0000_0000_0000_2710
`define TONE_SYMS 64'h0000_0000_0000_0008
// symbol index bit that selects the negative half of the tone
`define TONE_NEG_BIT 2

// customer wake tone length in frames
`define CUST_TONE_FRAMES 3'h6

// user bit fill while not transparent, customer side
`define CUST_FILL_BIT 1'h1
// user bit shown to terminal while not transparent
`define TE_IDLE_BIT 1'h1

`endif

// File: include/loop_seq_pkg.sv
// types of the loop transceiver start-up sequencer
// assumes the defines header is included by every user
package loop_seq_pkg;

    // sequencer states of the customer side termination
    typedef enum logic [3:0] {
        FULL_RESET,
        RECV_RESET,
        WAKE_TONE,
        PATTERN_ONE,
        SILENT_WAIT,
        RX_TRAIN,
        PATTERN_TWO,
        PATTERN_FINAL,
        CEASE_WAIT
    } seq_state_e;

    // transition point index, 0 to 7
    typedef logic [2:0] t_point_t;

    // counter word for long timers
    typedef logic [31:0] count_t;

endpackage

// File: verilog/wake_tone_gen.sv
// wake tone symbol generator: four +3 symbols then four -3 symbols, unframed
// assumes tone_on comes from logic on sys_clk; restarts at the positive half
`timescale 1ns/1ps
`include "loop_seq_defines.svh"

module wake_tone_gen
    import loop_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic tone_on,
    output logic tone_positive,
    output logic tone_strobe
);

    // cycles per tone symbol
    localparam count_t SYM_CYC = 32'(`CLK_HZ / (`TONE_HZ * `TONE_SYMS));

    logic [31:0] div_reg;
    logic [31:0] div_next;
    logic [2:0] sym_reg;
    logic [2:0] sym_next;

    // symbol divider and index, held at zero while the tone is off
    always_comb begin
        div_next = div_reg;
        sym_next = sym_reg;
        if (!tone_on) begin
            div_next = 32'h0000_0000;
            sym_next = 3'h0;
        end else if (div_reg == SYM_CYC - 32'h0000_0001) begin
            div_next = 32'h0000_0000;
            sym_next = sym_reg + 3'h1;
        end else begin
            div_next = div_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= 32'h0000_0000;
            sym_reg <= 3'h0;
        end else begin
            div_reg <= div_next;
            sym_reg <= sym_next;
        end
    end

    // sign and symbol strobe for the line coder
    assign tone_positive = tone_on && !sym_reg[`TONE_NEG_BIT];
    assign tone_strobe = tone_on && (div_reg == 32'h0000_0000);

endmodule

// File: test/exchange_end_model.sv
// model of the exchange side termination at the far end of the line
// assumes bench commands for wake tone, turn-off, hold and activation bit
`timescale 1ns/1ps
module exchange_end_model
    import loop_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic tx_on,
    input wire logic tone_on,
    input wire t_point_t t_point,
    input wire logic wake_cmd,
    input wire logic turnoff_cmd,
    input wire logic hold_cmd,
    input wire logic act_cmd,
    input wire logic user_bit,
    output logic signal_detect,
    output logic exchange_wake_tone_detect,
    output logic frame_sync_acquired,
    output logic exchange_pattern_two_detect,
    output logic multiframe_acquired,
    output logic far_activation_bit,
    output logic far_deact_bit,
    output logic line_user_bit
);
    logic armed_reg;
    logic [7:0] run_reg;
    logic [7:0] off_reg;
    logic wake_q, turnoff_q, hold_q, act_q, user_q;

    // bench commands taken on the rising edge, so the falling edge work never races them
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            {wake_q, turnoff_q, hold_q, act_q, user_q} <= 5'h00;
        end else begin
            {wake_q, turnoff_q, hold_q, act_q, user_q} <=
                {wake_cmd, turnoff_cmd, hold_cmd, act_cmd, user_bit};
        end
    end

    // far end state, changed away from the edge the sequencer samples on
    always @(negedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_reg <= 1'b0;
            run_reg <= 8'h00;
            off_reg <= 8'h00;
            signal_detect <= 1'b0;
            exchange_wake_tone_detect <= 1'b0;
            frame_sync_acquired <= 1'b0;
            exchange_pattern_two_detect <= 1'b0;
            multiframe_acquired <= 1'b0;
            far_activation_bit <= 1'b0;
            far_deact_bit <= 1'b1;
            line_user_bit <= 1'b0;
        end else begin
            exchange_wake_tone_detect <= wake_q;
            if (t_point == 3'h1 && !tone_on) armed_reg <= 1'b1;
            // answer the end of pattern one with signal of our own
            if (armed_reg && !tx_on && !hold_q) begin
                armed_reg <= 1'b0;
                signal_detect <= 1'b1;
            end
            run_reg <= signal_detect ? run_reg + {7'h00, run_reg != 8'hff} : 8'h00;
            frame_sync_acquired <= signal_detect && run_reg >= 8'h08;
            exchange_pattern_two_detect <= signal_detect && run_reg >= 8'h08;
            multiframe_acquired <= signal_detect && run_reg >= 8'h10;
            far_activation_bit <= act_q && t_point == 3'h6;
            line_user_bit <= signal_detect ? user_q : !line_user_bit;
            far_deact_bit <= off_reg == 8'h00;
            if (turnoff_q && signal_detect) off_reg <= 8'h01;
            else if (off_reg != 8'h00) off_reg <= off_reg + 8'h01;
            // announced turn-off ends with the line going quiet
            if (off_reg == 8'h10) begin
                off_reg <= 8'h00;
                signal_detect <= 1'b0;
            end
        end
    end
endmodule

// File: test/tb_top.sv
// bench for the start-up sequencer of the customer side termination
// assumes the exchange side model and shortened timer parameters
`timescale 1ns/1ps
module tb_top
    import loop_seq_pkg::*;
;
    typedef struct packed {logic act, eq, lb, te_in, ln, tx, te, tr, fo;} row_s;
    logic sys_clk, arst_n, service_request, line_changed, echo_converged;
    logic equalizer_converged, loopback_req, te_user_bit_in, wake_cmd, turnoff_cmd;
    logic hold_cmd, act_cmd, user_bit, signal_detect, exchange_wake_tone_detect;
    logic frame_sync_acquired, exchange_pattern_two_detect, multiframe_acquired;
    logic far_activation_bit, far_deact_bit, line_user_bit, tx_on, tone_on;
    logic tone_positive, tone_strobe, scramble_en, inverted_sync_en, overhead_normal;
    logic tx_user_bit, te_user_bit, transparent, full_operational, warm_start;
    logic frame_tick = 1'b0;
    t_point_t t_point;
    int mismatches = 0, checks = 0, frame_period = 4000, fcnt = 0;
    int hi, lo, ph, ticks, n, st;
    row_s rows [6] = '{9'h08d, 9'h0c5, 9'h197, 9'h1ab, 9'h1d7, 9'h10c};

    loop_transceiver_startup_sequencer #(.RECV_RESET_CYC(32'h0000_0014),
        .LOSS_LIMIT_CYC(32'h0000_0032), .STARTUP_LIMIT_CYC(32'h0000_7530)) dut (
        .sys_clk, .arst_n, .frame_tick, .signal_detect, .exchange_wake_tone_detect,
        .service_request, .line_changed, .frame_sync_acquired, .exchange_pattern_two_detect,
        .multiframe_acquired, .echo_converged, .equalizer_converged, .far_activation_bit,
        .far_deact_bit, .loopback_req, .line_user_bit, .te_user_bit_in, .tx_on, .tone_on,
        .tone_positive, .tone_strobe, .scramble_en, .inverted_sync_en, .overhead_normal,
        .tx_user_bit, .te_user_bit, .transparent, .full_operational, .warm_start, .t_point);
    exchange_end_model far_end (.sys_clk, .arst_n, .tx_on, .tone_on, .t_point, .wake_cmd,
        .turnoff_cmd, .hold_cmd, .act_cmd, .user_bit, .signal_detect,
        .exchange_wake_tone_detect, .frame_sync_acquired, .exchange_pattern_two_detect,
        .multiframe_acquired, .far_activation_bit, .far_deact_bit, .line_user_bit);

    // 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // free running frame boundary pulse
    always @(negedge sys_clk) begin
        fcnt <= (fcnt >= frame_period - 1) ? 0 : fcnt + 1;
        frame_tick <= (fcnt == frame_period - 1);
    end

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_tp(input t_point_t got, input t_point_t exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        checks++;
        if (got != exp) begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_tp(input t_point_t tp, input int lim);
        int k;
        k = 0;
        while (t_point !== tp && k < lim) begin
            k++;
            @(negedge sys_clk);
        end
        chk_tp(t_point, tp);
    endtask

    task automatic end_test(input string name);
        $display("test %s done: checks %0d mismatches %0d", name, checks, mismatches);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // tone end, pattern one, silence, training, pattern two, final pattern
    task automatic walk_to_final();
        int k;
        k = 0;
        while (tone_on !== 1'b0 && k < 30000) begin
            k++;
            @(negedge sys_clk);
        end
        frame_period = 40;
        chk_bit(tone_on, 1'b0);
        chk_bit(scramble_en, 1'b1);
        chk_bit(inverted_sync_en, 1'b0);
        chk_bit(overhead_normal, 1'b0);
        chk_bit(tx_user_bit, 1'b1);
        echo_converged = 1'b1;
        @(negedge sys_clk);
        chk_bit(tx_on, 1'b0);
        chk_tp(t_point, 3'h2);
        wait_tp(3'h3, 10);
        wait_tp(3'h5, 20);
        chk_bit(tx_on, 1'b1);
        chk_bit(inverted_sync_en, 1'b0);
        wait_tp(3'h6, 20);
        chk_bit(full_operational, 1'b1);
        chk_bit(inverted_sync_en, 1'b1);
        chk_bit(overhead_normal, 1'b1);
    endtask

    // announced turn-off, then wait for the receive reset sub-state
    task automatic turn_off();
        turnoff_cmd = 1'b1;
        @(negedge sys_clk);
        turnoff_cmd = 1'b0;
        wait_tp(3'h0, 40);
        chk_bit(tx_on, 1'b0);
    endtask

    // cut a hung run short
    initial begin
        repeat (60000) @(posedge sys_clk);
        mismatches++;
        print_verdict();
    end

    // main sequence
    initial begin
        {arst_n, service_request, line_changed, echo_converged, loopback_req} = 5'h00;
        {wake_cmd, turnoff_cmd, hold_cmd, act_cmd, user_bit} = 5'h00;
        {equalizer_converged, te_user_bit_in} = 2'h3;
        repeat (3) @(negedge sys_clk);
        chk_bit(tx_on, 1'b0);
        chk_bit(tone_on, 1'b0);
        chk_tp(t_point, 3'h0);
        arst_n = 1'b1;
        @(negedge sys_clk);
        chk_bit(tone_on, 1'b1);
        chk_bit(scramble_en, 1'b0);
        chk_bit(warm_start, 1'b0);
        {hi, lo, ph, ticks, n, st} = 0;
        while (tone_on === 1'b1 && n < 30000) begin
            if (ph == 0 && tone_positive === 1'b1) hi++;
            else if (ph == 0) {ph, lo} = {32'd1, 32'd1};
            else if (ph == 1 && tone_positive === 1'b0) lo++;
            else ph = 2;
            if (ph == 0 && tone_strobe === 1'b1) st++;
            n++;
            @(negedge sys_clk);
            if (frame_tick === 1'b1) ticks++;
        end
        chk_cnt(hi, 10000);
        chk_cnt(lo, 10000);
        chk_cnt(st, 4);
        chk_cnt(ticks, 6);
        walk_to_final();
        end_test("power-up start");
        foreach (rows[i]) begin
            {act_cmd, equalizer_converged, loopback_req} = {rows[i].act, rows[i].eq, rows[i].lb};
            {te_user_bit_in, user_bit} = {rows[i].te_in, rows[i].ln};
            repeat (4) @(negedge sys_clk);
            chk_bit(tx_user_bit, rows[i].tx);
            chk_bit(te_user_bit, rows[i].te);
            chk_bit(transparent, rows[i].tr);
            chk_bit(full_operational, rows[i].fo);
        end
        end_test("transparency");
        {act_cmd, equalizer_converged, loopback_req, echo_converged} = 4'h4;
        turn_off();
        repeat (15) @(negedge sys_clk);
        service_request = 1'b1;
        repeat (30) @(negedge sys_clk);
        chk_bit(tone_on, 1'b0);
        service_request = 1'b0;
        @(negedge sys_clk);
        service_request = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk_bit(tone_on, 1'b1);
        chk_bit(warm_start, 1'b1);
        walk_to_final();
        end_test("turn-off and service request");
        turn_off();
        {echo_converged, hold_cmd, wake_cmd} = 3'h3;
        repeat (2) @(negedge sys_clk);
        chk_bit(tone_on, 1'b1);
        chk_bit(warm_start, 1'b1);
        repeat (10) @(negedge sys_clk);
        wake_cmd = 1'b0;
        repeat (300) @(negedge sys_clk);
        echo_converged = 1'b1;
        wait_tp(3'h2, 5);
        repeat (45) @(negedge sys_clk);
        chk_tp(t_point, 3'h2);
        wait_tp(3'h0, 10);
        repeat (100) @(negedge sys_clk);
        chk_bit(tone_on, 1'b0);
        service_request = 1'b0;
        @(negedge sys_clk);
        service_request = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk_bit(tone_on, 1'b1);
        chk_bit(warm_start, 1'b0);
        end_test("wake answer and loss limit");
        print_verdict();
    end
endmodule
